// ==== shared/trim_pkg.sv ====
// Functional notes
// - mode code 1 lock/blow, code 2 try
// - gain code 9 bits, two ranges
// - duty code 0 preset, rising to max
// - duty top bit set means decreasing duty
// - carrier code rising lowers frequency, 15 min
// - carrier code bit 4 enables calibration
// - key 6 code 512 addresses lock fuse
// - blown calibration bit enters interval each powerup
// - calibration interval forces quiescent duty output
// - after interval output follows field again
// - interval length scales inversely with carrier
// - mid pulse falling edge increments, saturating
// - power cycle clears unblown bits only
// - try mode high pulse cycles selection states
// - lock fuse blown rejects all programming
package trim_pkg;
  localparam int CODE_W = 10;
  localparam logic [1:0] MODE_BLOW = 2'h1; // lock or blow
  localparam logic [1:0] MODE_TRY = 2'h2;
  localparam logic [2:0] KEY_GAIN = 3'h1;
  localparam logic [2:0] KEY_DUTY = 3'h2;
  localparam logic [2:0] KEY_CARRIER = 3'h3;
  localparam logic [2:0] KEY_LOCK = 3'h6;
  localparam logic [8:0] GAIN_MAX = 9'h1ff;
  localparam logic [8:0] DUTY_MAX = 9'h1ff;
  localparam logic [8:0] CARRIER_MAX = 9'h01f; // bits 3:0 plus calibration bit
  localparam logic [9:0] LOCK_CODE = 10'h200;
  localparam int GAIN_RANGE_BIT = 8;
  localparam int DUTY_DOWN_BIT = 8;
  localparam int CAL_EN_BIT = 4;
  localparam logic [3:0] CARRIER_FREQ_MAX = 4'hf;
  localparam logic [7:0] CAL_PERIODS = 8'h32; // 50 periods at 1 kHz = 50 ms
  localparam int CAL_TIME_MS = 50;
  localparam int CAL_REF_HZ = 1000;
  typedef enum logic [1:0] {
    ST_MODE = 2'b00,
    ST_KEY = 2'b01,
    ST_FIELD = 2'b11
  } prog_state_t;
  typedef enum logic [1:0] {
    CAL_IDLE = 2'b00,
    CAL_RUN = 2'b01,
    CAL_DONE = 2'b11
  } cal_state_t;
endpackage

// ==== logic/pulse_sync.sv ====
`timescale 1ns/1ns
// two-stage synchroniser with falling and rising edge pulses
module pulse_sync (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic pinIn,
  output logic rise,
  output logic fall
);
  logic meta_r;
  logic sync_r;
  logic last_r;
  // first stage read only by second stage
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      meta_r <= 1'b0;
      sync_r <= 1'b0;
      last_r <= 1'b0;
    end else begin
      meta_r <= pinIn;
      sync_r <= meta_r;
      last_r <= sync_r;
    end
  end
  assign rise = sync_r & ~last_r;
  assign fall = ~sync_r & last_r;
endmodule // pulse_sync

// ==== logic/cal_timer.sv ====
`timescale 1ns/1ns
// counts carrier periods after power-up while calibration is enabled
module cal_timer
  import trim_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic calEnable,
  input wire logic carrierTick,
  output logic calActive
);
  cal_state_t state_r;
  cal_state_t state_nxt;
  logic [7:0] count_r;
  logic [7:0] count_nxt;
  wire lastTick = carrierTick && (count_r == CAL_PERIODS - 8'h01);

  // period count, so length follows carrier rate
  always_comb begin
    state_nxt = state_r;
    count_nxt = count_r;
    case (state_r)
      CAL_IDLE: begin
        if (calEnable) begin
          state_nxt = CAL_RUN;
        end else begin
          state_nxt = CAL_DONE;
        end
        count_nxt = 8'h00;
      end
      CAL_RUN: begin
        if (lastTick) begin
          state_nxt = CAL_DONE;
        end else if (carrierTick) begin
          count_nxt = count_r + 8'h01;
        end
      end
      CAL_DONE: state_nxt = CAL_DONE;
      default: state_nxt = CAL_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      state_r <= CAL_IDLE;
      count_r <= 8'h00;
    end else begin
      state_r <= state_nxt;
      count_r <= count_nxt;
    end
  end

  assign calActive = (state_r == CAL_RUN);

  // interval ends exactly after 50 carrier ticks
  property p_cal_len;
    @(posedge sys_clk) disable iff (rst)
      (state_r == CAL_RUN && lastTick) |=> !calActive;
  endproperty
  a_cal_len: assert property (p_cal_len) else $error("interval did not end");
  property p_cal_hold;
    @(posedge sys_clk) disable iff (rst)
      (state_r == CAL_RUN && !carrierTick) |=> calActive;
  endproperty
  a_cal_hold: assert property (p_cal_hold) else $error("interval ended early");
  c_cal_end: cover property (@(posedge sys_clk) disable iff (rst) $fell(calActive));
endmodule // cal_timer

// ==== logic/fuse_trim_programming_logic.sv ====
`timescale 1ns/1ns
// supply-pulse programming logic with fuse trim and calibration sequencing
module fuse_trim_programming_logic
  import trim_pkg::*;
#(
  parameter int CODE_WIDTH = CODE_W
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic midPulse,
  input wire logic highPulse,
  input wire logic [8:0] gainFuses,
  input wire logic [8:0] dutyFuses,
  input wire logic [8:0] carrierFuses,
  input wire logic lockFuse,
  input wire logic carrierTick,
  input wire logic [15:0] fieldDuty,
  output logic blowStrobe,
  output logic [1:0] blowKey,
  output logic [9:0] blowBit,
  output logic [8:0] gain_setting_code,
  output logic gainRange,
  output logic [7:0] dutyStep,
  output logic dutyDecreasing,
  output logic [3:0] carrier_frequency,
  output logic calActive,
  output logic useFieldDuty,
  output logic inBlowMode,
  output logic locked
);
  ////////////////////////////////////////////////////////////////////
  // pin edges
  logic midFall;
  logic highRise;
  logic highFall;
  pulse_sync midSync (
    .sys_clk(sys_clk),
    .rst(rst),
    .pinIn(midPulse),
    .rise(),
    .fall(midFall)
  );
  pulse_sync highSync (
    .sys_clk(sys_clk),
    .rst(rst),
    .pinIn(highPulse),
    .rise(highRise),
    .fall(highFall)
  );

  ////////////////////////////////////////////////////////////////////
  // selection state
  prog_state_t state_r;
  prog_state_t state_nxt;
  logic [1:0] mode_r;
  logic [1:0] mode_nxt;
  logic [2:0] key_r;
  logic [2:0] key_nxt;
  logic [CODE_WIDTH-1:0] code_r;
  logic [CODE_WIDTH-1:0] code_nxt;
  logic [8:0] gainTry_r;
  logic [8:0] dutyTry_r;
  logic [8:0] carrierTry_r;
  logic lockSticky_r;
  logic blow_r;

  // latched fuses; lock fuse refuses all further work
  wire isLocked = lockFuse;
  wire progOk = !isLocked;
  wire modeTry = (mode_r == MODE_TRY);
  wire modeBlow = (mode_r == MODE_BLOW);
  // field limit per key; an unknown key takes no counts
  wire [CODE_WIDTH-1:0] keyFieldMax =
    (key_r == KEY_GAIN) ? CODE_WIDTH'(GAIN_MAX) :
    (key_r == KEY_DUTY) ? CODE_WIDTH'(DUTY_MAX) :
    (key_r == KEY_CARRIER) ? CODE_WIDTH'(CARRIER_MAX) :
    (key_r == KEY_LOCK) ? CODE_WIDTH'(LOCK_CODE) : '0;
  // limit follows the stage: a key left over from an earlier pass
  // would otherwise clip mode and key codes at its own field limit
  wire [CODE_WIDTH-1:0] fieldMax =
    (state_r == ST_MODE) ? CODE_WIDTH'(MODE_TRY) :
    (state_r == ST_KEY) ? CODE_WIDTH'(KEY_LOCK) : keyFieldMax;
  wire atMax = (code_r >= fieldMax);
  wire [CODE_WIDTH-1:0] codeStep = code_r + CODE_WIDTH'(1);
  // lock field jumps straight from zero to its only code
  wire lockJump = (state_r == ST_FIELD) && (key_r == KEY_LOCK);
  wire [CODE_WIDTH-1:0] codeInc = lockJump ? fieldMax : codeStep;

  // mid falls count codes; high pulses step selection
  always_comb begin
    state_nxt = state_r;
    mode_nxt = mode_r;
    key_nxt = key_r;
    code_nxt = code_r;
    if (progOk) begin
      if (midFall && !atMax) begin
        code_nxt = codeInc;
      end
      if (highFall) begin
        case (state_r)
          ST_MODE: begin
            if (code_r == CODE_WIDTH'(MODE_BLOW) || code_r == CODE_WIDTH'(MODE_TRY)) begin
              mode_nxt = code_r[1:0];
              state_nxt = ST_KEY;
            end
            code_nxt = '0;
          end
          ST_KEY: begin
            key_nxt = code_r[2:0];
            state_nxt = ST_FIELD;
            code_nxt = '0;
          end
          ST_FIELD: begin
            // try loops back to key choice; blow keeps field for next pulse
            if (modeTry) begin
              state_nxt = ST_KEY;
              code_nxt = '0;
            end
          end
          default: state_nxt = ST_MODE;
        endcase
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      state_r <= ST_MODE;
      mode_r <= 2'h0;
      key_r <= 3'h0;
      code_r <= '0;
    end else begin
      state_r <= state_nxt;
      mode_r <= mode_nxt;
      key_r <= key_nxt;
      code_r <= code_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // try values held until power cycle; reset clears unblown bits
  wire inField = (state_r == ST_FIELD);
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      gainTry_r <= 9'h000;
      dutyTry_r <= 9'h000;
      carrierTry_r <= 9'h000;
      lockSticky_r <= 1'b0;
    end else if (inField && progOk) begin
      if (key_r == KEY_GAIN) begin
        gainTry_r <= code_r[8:0];
      end
      if (key_r == KEY_DUTY) begin
        dutyTry_r <= code_r[8:0];
      end
      if (key_r == KEY_CARRIER) begin
        carrierTry_r <= code_r[8:0];
      end
      if (key_r == KEY_LOCK && code_r == LOCK_CODE) begin
        lockSticky_r <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // blow request: high pulse while field addressed in blow mode
  wire blowReq = highRise && inField && modeBlow && progOk;
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      blow_r <= 1'b0;
      blowKey <= 2'h0;
      blowBit <= 10'h000;
    end else begin
      blow_r <= blowReq;
      if (blowReq) begin
        blowKey <= key_r[1:0];
        blowBit <= code_r; // lock fuse at code 512
      end
    end
  end
  assign blowStrobe = blow_r;

  ////////////////////////////////////////////////////////////////////
  // effective codes: blown fuses or-ed with addressed bits
  wire [8:0] gainEff = gainFuses | gainTry_r;
  wire [8:0] dutyEff = dutyFuses | dutyTry_r;
  wire [8:0] carrierEff = carrierFuses | carrierTry_r;
  // only the blown fuse enables calibration, never a try value
  wire calEnable = carrierFuses[CAL_EN_BIT];

  assign gain_setting_code = gainEff;
  assign gainRange = gainEff[GAIN_RANGE_BIT];
  assign dutyStep = dutyEff[7:0];
  assign dutyDecreasing = dutyEff[DUTY_DOWN_BIT];
  assign carrier_frequency = carrierEff[3:0];
  assign inBlowMode = modeBlow;
  assign locked = isLocked | lockSticky_r;

  ////////////////////////////////////////////////////////////////////
  // calibration interval sequencer
  cal_timer calTimer (
    .sys_clk(sys_clk),
    .rst(rst),
    .calEnable(calEnable),
    .carrierTick(carrierTick),
    .calActive(calActive)
  );
  // quiescent duty forced while the interval runs
  assign useFieldDuty = !calActive;

  ////////////////////////////////////////////////////////////////////
  // checks: lock refusal
  // a fuse that reads locked must freeze the code and selection state registers
  property p_lock_freeze;
    @(posedge sys_clk) disable iff (rst)
      isLocked |=> $stable(code_r) && $stable(state_r);
  endproperty
  a_lock_freeze: assert property (p_lock_freeze) else $error("locked part changed");

  property p_no_blow_locked;
    @(posedge sys_clk) disable iff (rst)
      isLocked && $past(isLocked) |-> !blowStrobe;
  endproperty
  a_no_blow_locked: assert property (p_no_blow_locked) else $error("blow while locked");

  ////////////////////////////////////////////////////////////////////
  // checks: code counting
  property p_inc;
    @(posedge sys_clk) disable iff (rst)
      (midFall && !atMax && progOk && !highFall && !lockJump) |=>
        code_r == $past(code_r) + CODE_WIDTH'(1);
  endproperty
  a_inc: assert property (p_inc) else $error("code did not step");

  property p_sat;
    @(posedge sys_clk) disable iff (rst)
      (atMax && !highFall) |=> code_r == $past(code_r);
  endproperty
  a_sat: assert property (p_sat) else $error("code passed maximum");

  // stage limits: mode codes must never pass MODE_TRY, key codes never KEY_LOCK
  property p_mode_range;
    @(posedge sys_clk) disable iff (rst)
      (state_r == ST_MODE) |-> code_r <= CODE_WIDTH'(MODE_TRY);
  endproperty
  a_mode_range: assert property (p_mode_range) else $error("mode code too big");

  property p_key_range;
    @(posedge sys_clk) disable iff (rst)
      (state_r == ST_KEY) |-> code_r <= CODE_WIDTH'(KEY_LOCK);
  endproperty
  a_key_range: assert property (p_key_range) else $error("key code too big");

  property p_lock_jump;
    @(posedge sys_clk) disable iff (rst)
      (progOk && lockJump && midFall && !highFall && code_r == '0) |=>
        code_r == CODE_WIDTH'(LOCK_CODE);
  endproperty
  a_lock_jump: assert property (p_lock_jump) else $error("lock code not reached");

  ////////////////////////////////////////////////////////////////////
  // checks: selection stepping
  property p_try_loop;
    @(posedge sys_clk) disable iff (rst)
      (progOk && highFall && inField && modeTry) |=> state_r == ST_KEY && code_r == '0;
  endproperty
  a_try_loop: assert property (p_try_loop) else $error("try did not loop");

  property p_mode;
    @(posedge sys_clk) disable iff (rst)
      (progOk && highFall && state_r == ST_MODE && code_r == CODE_WIDTH'(MODE_TRY))
        |=> modeTry && state_r == ST_KEY;
  endproperty
  a_mode: assert property (p_mode) else $error("mode not taken");

  // try values move only while a field is addressed
  property p_try_keep;
    @(posedge sys_clk) disable iff (rst)
      !inField |=> $stable(gainTry_r) && $stable(dutyTry_r) && $stable(carrierTry_r);
  endproperty
  a_try_keep: assert property (p_try_keep) else $error("try value moved");

  ////////////////////////////////////////////////////////////////////
  // checks: blow requests
  // a strobe must trace back to an addressed field in blow mode
  property p_blow;
    @(posedge sys_clk) disable iff (rst) blowReq |=> blowStrobe && blowBit == $past(code_r);
  endproperty
  a_blow: assert property (p_blow) else $error("blow not issued");

  property p_blow_field;
    @(posedge sys_clk) disable iff (rst) blowStrobe |-> $past(inField) && $past(modeBlow);
  endproperty
  a_blow_field: assert property (p_blow_field) else $error("blow outside field");

  property p_strobe_pulse;
    @(posedge sys_clk) disable iff (rst) blowStrobe |=> !blowStrobe;
  endproperty
  a_strobe_pulse: assert property (p_strobe_pulse) else $error("strobe too long");

  ////////////////////////////////////////////////////////////////////
  // checks: calibration output
  property p_cal_out;
    @(posedge sys_clk) disable iff (rst) calActive |-> !useFieldDuty;
  endproperty
  a_cal_out: assert property (p_cal_out) else $error("field leaked in calibration");

  property p_cal_need;
    @(posedge sys_clk) disable iff (rst) !calEnable |-> !calActive;
  endproperty
  a_cal_need: assert property (p_cal_need) else $error("calibration without fuse");

  // scenario covers
  c_try: cover property (@(posedge sys_clk) disable iff (rst) highFall && inField && modeTry);
  c_blow: cover property (@(posedge sys_clk) disable iff (rst) blowStrobe);
  c_lock: cover property (@(posedge sys_clk) disable iff (rst) lockSticky_r);
  c_sat: cover property (@(posedge sys_clk) disable iff (rst) midFall && atMax && inField);
endmodule // fuse_trim_programming_logic

// ==== dv/supply_programmer.sv ====
`timescale 1ns/1ns
// programmer model: supply level shown as mid and high level flags
module supply_programmer (
  input wire logic sys_clk,
  output logic midPulse,
  output logic highPulse
);
  initial begin
    midPulse = 1'b0;
    highPulse = 1'b0;
  end
  //////////////////////////////////////////////////////////////////////////////
  // level held 6 cycles, gap 6 cycles: well clear of the 4 cycle spacing
  task automatic pulse(input bit high, input int n);
    for (int k = 0; k < n; k++) begin
      @(negedge sys_clk);
      if (high) highPulse = 1'b1;
      else midPulse = 1'b1;
      repeat (6) @(negedge sys_clk);
      highPulse = 1'b0;
      midPulse = 1'b0;
      repeat (5) @(negedge sys_clk);
    end
  endtask
endmodule // supply_programmer

// ==== dv/fuse_trim_programming_logic_bench.sv ====
`timescale 1ns/1ns
module fuse_trim_programming_logic_bench;
  import trim_pkg::*;
  typedef struct packed {logic [2:0] key; int n; logic [8:0] exp;} row_t;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic midPulse;
  logic highPulse;
  logic lockFuse = 1'b0;
  logic carrierTick = 1'b0;
  logic [8:0] gainFuses = 9'h000;
  logic [8:0] dutyFuses = 9'h000;
  logic [8:0] carrierFuses = 9'h000;
  logic blowStrobe, gainRange, dutyDecreasing, calActive, useFieldDuty, inBlowMode, locked;
  logic [1:0] blowKey;
  logic [9:0] blowBit;
  logic [8:0] gain_setting_code;
  logic [7:0] dutyStep;
  logic [3:0] carrier_frequency;
  logic [1:0] lastKey = 2'h0;
  logic [9:0] lastBit = 10'h000;
  int strobeCnt = 0;
  int error_cnt = 0;
  int cmp_count = 0;
  int cycles = 0;
  // awkward cases: range edges, direction switch, saturation past max
  row_t rows[6] = '{'{KEY_GAIN, 255, 9'h0ff}, '{KEY_GAIN, 256, 9'h100},
    '{KEY_DUTY, 3, 9'h003}, '{KEY_DUTY, 257, 9'h101},
    '{KEY_CARRIER, 15, 9'h00f}, '{KEY_CARRIER, 40, 9'h00f}};

  always #2 sys_clk = ~sys_clk;

  supply_programmer i_prog (.sys_clk(sys_clk), .midPulse(midPulse), .highPulse(highPulse));

  fuse_trim_programming_logic i_dut (.sys_clk(sys_clk), .rst(rst), .midPulse(midPulse),
    .highPulse(highPulse), .gainFuses(gainFuses), .dutyFuses(dutyFuses),
    .carrierFuses(carrierFuses), .lockFuse(lockFuse), .carrierTick(carrierTick),
    .fieldDuty(16'h0000), .blowStrobe(blowStrobe), .blowKey(blowKey), .blowBit(blowBit),
    .gain_setting_code(gain_setting_code), .gainRange(gainRange), .dutyStep(dutyStep),
    .dutyDecreasing(dutyDecreasing), .carrier_frequency(carrier_frequency),
    .calActive(calActive), .useFieldDuty(useFieldDuty), .inBlowMode(inBlowMode),
    .locked(locked));
  //////////////////////////////////////////////////////////////////////////////
  // strobe monitor and hang guard; ceiling well above the ~11k cycle run
  // sampled mid-cycle so the registered strobe is settled
  always @(negedge sys_clk) begin
    cycles <= cycles + 1;
    if (blowStrobe === 1'b1) begin
      strobeCnt <= strobeCnt + 1;
      lastBit <= blowBit;
      lastKey <= blowKey;
    end
    if (cycles == 60000) begin
      error_cnt++;
      $display("Error timeout expected finish seen hang");
      complete_run();
    end
  end
  //////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string name, input logic [9:0] exp, input logic [9:0] got);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic complete_run();
    $display("checks %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  // supply cycle: unblown trim bits drop back
  task automatic do_reset();
    @(negedge sys_clk);
    rst = 1'b1;
    repeat (8) @(negedge sys_clk);
    rst = 1'b0;
    repeat (4) @(negedge sys_clk);
  endtask

  task automatic tick(input int n);
    repeat (n) begin
      @(negedge sys_clk);
      carrierTick = 1'b1;
      @(negedge sys_clk);
      carrierTick = 1'b0;
      repeat (2) @(negedge sys_clk);
    end
  endtask

  function automatic logic [8:0] field(input logic [2:0] key);
    if (key == KEY_GAIN) return gain_setting_code;
    if (key == KEY_DUTY) return {dutyDecreasing, dutyStep};
    return {5'h00, carrier_frequency};
  endfunction
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    do_reset();
    chk("cal idle", 10'h000, {9'h000, calActive});
    foreach (rows[i]) begin
      i_prog.pulse(1'b0, 2);
      i_prog.pulse(1'b1, 1);
      i_prog.pulse(1'b0, int'(rows[i].key));
      i_prog.pulse(1'b1, 1);
      i_prog.pulse(1'b0, rows[i].n);
      chk("field code", {1'b0, rows[i].exp}, {1'b0, field(rows[i].key)});
      if (rows[i].key == KEY_GAIN) chk("gain range", {9'h000, rows[i].exp[8]}, {9'h000, gainRange});
      do_reset();
      chk("cleared", 10'h000, {1'b0, field(rows[i].key)});
      $display("row %0d done", i);
    end
    // try loop: two keys addressed in one session, both held
    i_prog.pulse(1'b0, 2);
    i_prog.pulse(1'b1, 1);
    i_prog.pulse(1'b0, 1);
    i_prog.pulse(1'b1, 1);
    i_prog.pulse(1'b0, 3);
    i_prog.pulse(1'b1, 1);
    i_prog.pulse(1'b0, 2);
    i_prog.pulse(1'b1, 1);
    i_prog.pulse(1'b0, 2);
    chk("try gain", 10'h003, {1'b0, gain_setting_code});
    chk("try duty", 10'h002, {2'h0, dutyStep});
    chk("try mode", 10'h000, {9'h000, inBlowMode});
    do_reset();
    $display("try loop done");
    // blow walk: carrier code 16 then a blow pulse
    i_prog.pulse(1'b0, 1);
    i_prog.pulse(1'b1, 1);
    i_prog.pulse(1'b0, 3);
    i_prog.pulse(1'b1, 1);
    i_prog.pulse(1'b0, 16);
    chk("blow mode", 10'h001, {9'h000, inBlowMode});
    i_prog.pulse(1'b1, 1);
    chk("strobes", 10'h001, strobeCnt[9:0]);
    chk("blow bit", 10'h010, lastBit);
    chk("blow key", 10'h003, {8'h00, lastKey});
    $display("blow walk done");
    // lock key: extra mid pulses must saturate at the lock code
    do_reset();
    i_prog.pulse(1'b0, 1);
    i_prog.pulse(1'b1, 1);
    i_prog.pulse(1'b0, 6);
    i_prog.pulse(1'b1, 1);
    i_prog.pulse(1'b0, 3);
    chk("locked", 10'h001, {9'h000, locked});
    i_prog.pulse(1'b1, 1);
    chk("lock bit", 10'h200, lastBit);
    lockFuse = 1'b1;
    do_reset();
    i_prog.pulse(1'b0, 2);
    i_prog.pulse(1'b1, 1);
    i_prog.pulse(1'b0, 1);
    i_prog.pulse(1'b1, 1);
    i_prog.pulse(1'b0, 3);
    chk("locked gain", 10'h000, {1'b0, gain_setting_code});
    lockFuse = 1'b0;
    $display("lock done");
    // blown bits survive the supply cycle; calibration bit blown
    gainFuses = 9'h005;
    carrierFuses = 9'h013;
    do_reset();
    chk("fuse gain", 10'h005, {1'b0, gain_setting_code});
    chk("fuse carrier", 10'h003, {6'h00, carrier_frequency});
    chk("cal start", 10'h001, {9'h000, calActive});
    chk("field off", 10'h000, {9'h000, useFieldDuty});
    tick(49);
    chk("cal hold", 10'h001, {9'h000, calActive});
    tick(1);
    chk("cal end", 10'h000, {9'h000, calActive});
    chk("field on", 10'h001, {9'h000, useFieldDuty});
    $display("calibration done");
    complete_run();
  end
endmodule // fuse_trim_programming_logic_bench
